// >>> dca_top.sv
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps

// How it works
// RL1: a far-end or near-end block error sets its status bit and bumps its counter.
// RL2: with rollover on a counter wraps FF to 00, otherwise it sticks at FF.
// RL3: a superframe tick every 12 ms, and every 100 of them mark one 1.2 s interval.
// RL4: once activated, transparent and with D-channel access on, software moves D-channel bytes.
// RL5: with the interrupt enabled and access on, each new D-channel byte loads status F.
// RL6: the D-channel byte event comes every 500 us while access is active.
// RL7: an activation event that meets a pending D-channel byte waits until that byte is read.
// RL8: at a 4.096 MHz data clock in GCI format eight 32-bit timeslots can be chosen.
// RL9: the timeslot number counts from zero and the slot carries data only when enabled.
// RL10: software pulses the reset bit once at power-up and the logic is held while it is 1.
// RL11: the overlay select bit maps the timeslot registers in; clearing it hides them again.
// RL12: software takes counter differences modulo 256 to cover a wrap.
// RL13: an enable bit gates the combined activation and D-channel interrupt.
// RL14: bit 3 of the interrupt source shows a pending activation or D-channel event.
// RL15: a successful activation shows status A or B.
// RL16: a failed activation shows status 4.
// RL17: reading the D-channel byte clears its pending flag and shows a held activation on the same edge.
module dca_top
    import dca_pkg::*;
#(
    parameter int DCH_CYCLES_P = DCH_CYCLES,
    parameter int SF_CYCLES_P  = SF_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [7:0]  avm_address,
    input  wire logic        avm_read,
    input  wire logic        avm_write,
    input  wire logic [3:0]  avm_byteenable,
    input  wire logic [31:0] avm_writedata,
    output logic      [31:0] avm_readdata,
    output logic             avm_waitrequest,
    input  wire logic        far_blk_err,
    input  wire logic        near_blk_err,
    input  wire logic        activated,
    input  wire logic        act_evt,
    input  wire logic [3:0]  act_code,
    input  wire logic [7:0]  dchan_rx_byte,
    output logic      [7:0]  dchan_tx_byte,
    output logic             dchan_strobe,
    output logic             act_request,
    output logic             cust_data_en,
    output logic      [2:0]  gci_slot_sel,
    output logic             gci_slot_on,
    output logic             sf_tick,
    output logic             interval_tick,
    output logic             act_dchan_irq,
    output logic             irq
);

    typedef struct packed {
        dca_bus_t               bus;
        logic                   waitrequest;
        logic [31:0]            rdata;
        logic                   srst;
        logic                   act_req;
        logic                   xparent;
        logic                   ie;
        logic                   ovl_sel;
        logic                   dch_acc;
        logic                   roll;
        logic                   far_st;
        logic                   near_st;
        logic [7:0]             far_cnt;
        logic [7:0]             near_cnt;
        logic [3:0]             nibble;
        logic                   act_pend;
        logic                   dch_pend;
        logic                   act_held;
        logic [3:0]             held_code;
        logic [7:0]             dch_rx;
        logic [7:0]             dch_tx;
        logic                   dch_tick;
        logic [GCI_SLOT_W-1:0]  gci_slot;
        logic [GCI_SLOTS-1:0]   slot_en;
        logic                   slot_on;
        logic [3:0]             irq_st;
        logic [3:0]             irq_mask;
        logic                   irq;
        logic                   act_irq;
        logic [DCH_TMR_W-1:0]   dch_tmr;
        logic [SF_TMR_W-1:0]    sf_tmr;
        logic [SF_CNT_W-1:0]    sf_cnt;
        logic                   sf_tick;
        logic                   intv_tick;
    } dca_state_t;

    dca_state_t s;
    dca_state_t next_s;

    logic wr_hit;
    logic rd_hit;
    logic rd_dch;
    logic access_on;
    logic dch_evt;
    logic sf_evt;

    // the access completes on the edge where waitrequest is seen low
    assign wr_hit    = avm_write && !s.waitrequest && avm_byteenable[0];
    assign rd_hit    = avm_read && !s.waitrequest;
    assign rd_dch    = rd_hit && avm_address == OFF_DCH_BYTE && s.dch_acc;
    assign access_on = activated && s.xparent && s.dch_acc && !s.srst; // RL4
    assign dch_evt   = access_on && s.dch_tmr == DCH_TMR_W'(DCH_CYCLES_P - 1); // RL6
    assign sf_evt    = s.sf_tmr == SF_TMR_W'(SF_CYCLES_P - 1); // RL3

    function automatic logic [31:0] read_mux(input dca_state_t st, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            OFF_CTRL0:    d[CTRL0_SRST_BIT] = st.srst;
            OFF_ACT_STAT: d[3:0] = st.nibble;
            OFF_ACT_CTRL: begin
                d[ACTC_XPARENT_BIT] = st.xparent;
                d[ACTC_REQ_BIT]     = st.act_req;
            end
            OFF_INT_SRC:  d[INTSRC_ACT_BIT] = st.act_pend || st.dch_pend; // RL14
            OFF_INT_EN:   d[INTEN_ACT_BIT] = st.ie;
            OFF_BLK_STAT: begin
                d[BLK_FAR_BIT]  = st.far_st;
                d[BLK_NEAR_BIT] = st.near_st;
            end
            OFF_FAR_CNT:  d[7:0] = st.far_cnt;
            OFF_NEAR_CNT: d[7:0] = st.near_cnt;
            OFF_OVL_SEL:  begin
                d[OVL_SEL_BIT]  = st.ovl_sel;
                d[OVL_DCH_BIT]  = st.dch_acc;
                d[OVL_ROLL_BIT] = st.roll;
            end
            OFF_GCI_SLOT: d[GCI_SLOT_W-1:0] = st.ovl_sel ? st.gci_slot : '0; // RL11
            OFF_SLOT_EN:  d[GCI_SLOTS-1:0] = st.ovl_sel ? st.slot_en : '0; // RL11
            OFF_DCH_BYTE: d[7:0] = st.dch_acc ? st.dch_rx : 8'h00; // RL4
            OFF_IRQ_STAT: d[3:0] = st.irq_st;
            OFF_IRQ_MASK: d[3:0] = st.irq_mask;
            OFF_SF_CNT:   d[SF_CNT_W-1:0] = st.sf_cnt;
            default:      d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // saturate or wrap, depending on the rollover option
    function automatic logic [7:0] bump(input logic [7:0] c, input logic roll);
        if (c == CNT_MAX) begin
            return roll ? CNT_ZERO : CNT_MAX; // RL2
        end
        return 8'(c + 8'h01);
    endfunction

    always_comb begin
        dca_bus_t    keep_bus;
        logic        keep_wait;
        logic [31:0] keep_rdata;
        keep_bus   = DCA_BUS_IDLE;
        keep_wait  = 1'b1;
        keep_rdata = 32'h0000_0000;
        next_s = s;
        next_s.sf_tick   = 1'b0;
        next_s.intv_tick = 1'b0;
        next_s.dch_tick  = 1'b0;

        // one wait cycle per access keeps read data a plain register
        next_s.waitrequest = 1'b1;
        next_s.bus         = DCA_BUS_IDLE;
        case (s.bus)
            DCA_BUS_IDLE: begin
                if (avm_read || avm_write) begin
                    next_s.bus         = DCA_BUS_ACK;
                    next_s.waitrequest = 1'b0;
                    next_s.rdata       = read_mux(s, avm_address);
                end
            end
            DCA_BUS_ACK: next_s.bus = DCA_BUS_IDLE;
            default:     next_s.bus = DCA_BUS_IDLE;
        endcase

        if (wr_hit) begin
            case (avm_address)
                OFF_CTRL0:    next_s.srst = avm_writedata[CTRL0_SRST_BIT]; // RL10
                OFF_ACT_CTRL: begin
                    next_s.xparent = avm_writedata[ACTC_XPARENT_BIT];
                    next_s.act_req = avm_writedata[ACTC_REQ_BIT];
                end
                OFF_INT_EN:   next_s.ie = avm_writedata[INTEN_ACT_BIT]; // RL13
                OFF_BLK_STAT: begin
                    next_s.far_st  = s.far_st && !avm_writedata[BLK_FAR_BIT];
                    next_s.near_st = s.near_st && !avm_writedata[BLK_NEAR_BIT];
                end
                OFF_FAR_CNT:  next_s.far_cnt = avm_writedata[7:0];
                OFF_NEAR_CNT: next_s.near_cnt = avm_writedata[7:0];
                OFF_OVL_SEL:  begin
                    next_s.ovl_sel = avm_writedata[OVL_SEL_BIT]; // RL11
                    next_s.dch_acc = avm_writedata[OVL_DCH_BIT];
                    next_s.roll    = avm_writedata[OVL_ROLL_BIT];
                end
                OFF_GCI_SLOT: if (s.ovl_sel) next_s.gci_slot = avm_writedata[GCI_SLOT_W-1:0];
                OFF_SLOT_EN:  if (s.ovl_sel) next_s.slot_en = avm_writedata[GCI_SLOTS-1:0];
                OFF_DCH_BYTE: if (s.dch_acc) next_s.dch_tx = avm_writedata[7:0]; // RL4
                OFF_IRQ_STAT: next_s.irq_st = s.irq_st & ~avm_writedata[3:0];
                OFF_IRQ_MASK: next_s.irq_mask = avm_writedata[3:0];
                default:      next_s.srst = s.srst;
            endcase
        end

        // reading the status nibble acknowledges an activation report
        if (rd_hit && avm_address == OFF_ACT_STAT) begin
            next_s.act_pend = 1'b0;
        end
        if (rd_dch) begin
            next_s.dch_pend = 1'b0; // RL17
            if (s.act_held) begin
                next_s.nibble   = s.held_code; // RL7
                next_s.act_pend = 1'b1;
                next_s.act_held = 1'b0;
            end
        end

        // timers: superframe, 1.2 s interval and the D-channel byte slot
        next_s.sf_tmr = sf_evt ? '0 : SF_TMR_W'(s.sf_tmr + 1'b1);
        if (sf_evt) begin
            next_s.sf_tick = 1'b1; // RL3
            if (s.sf_cnt == SF_CNT_W'(SF_PER_INTERVAL - 1)) begin
                next_s.sf_cnt    = '0;
                next_s.intv_tick = 1'b1; // RL3
            end else begin
                next_s.sf_cnt = SF_CNT_W'(s.sf_cnt + 1'b1);
            end
        end
        next_s.dch_tmr = (!access_on || dch_evt) ? '0 : DCH_TMR_W'(s.dch_tmr + 1'b1);

        // events are applied last so a set beats a clear in the same cycle
        if (far_blk_err) begin
            next_s.far_st  = 1'b1; // RL1
            next_s.far_cnt = bump(s.far_cnt, s.roll); // RL1
            next_s.irq_st[IRQ_FAR_BIT] = 1'b1;
        end
        if (near_blk_err) begin
            next_s.near_st  = 1'b1; // RL1
            next_s.near_cnt = bump(s.near_cnt, s.roll); // RL1
            next_s.irq_st[IRQ_NEAR_BIT] = 1'b1;
        end
        if (dch_evt) begin
            next_s.dch_rx   = dchan_rx_byte; // RL4
            next_s.dch_tick = 1'b1;
            next_s.dch_pend = 1'b1; // RL6
            next_s.irq_st[IRQ_DCH_BIT] = 1'b1;
            if (s.ie) begin
                next_s.nibble = CODE_DCH; // RL5
            end
        end
        if (act_evt) begin
            next_s.irq_st[IRQ_ACT_BIT] = 1'b1;
            if (s.dch_pend || dch_evt) begin
                // held so the controller never loses the byte status F
                next_s.act_held  = 1'b1; // RL7
                next_s.held_code = act_code;
            end else begin
                next_s.nibble   = act_code; // RL15 RL16
                next_s.act_pend = 1'b1;
            end
        end

        next_s.slot_on = next_s.slot_en[next_s.gci_slot]; // RL9
        next_s.irq     = |(next_s.irq_st & next_s.irq_mask);
        next_s.act_irq = next_s.ie && (next_s.act_pend || next_s.dch_pend); // RL13

        // soft reset clears everything but the bus handshake, the read data and the bit itself
        if (next_s.srst) begin
            keep_bus   = next_s.bus;
            keep_wait  = next_s.waitrequest;
            keep_rdata = next_s.rdata;
            next_s             = '0; // RL10
            next_s.srst        = 1'b1;
            next_s.bus         = keep_bus;
            next_s.waitrequest = keep_wait;
            next_s.rdata       = keep_rdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s             <= '0;
            s.waitrequest <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign avm_readdata    = s.rdata;
    assign avm_waitrequest = s.waitrequest;
    assign dchan_tx_byte   = s.dch_tx;
    assign dchan_strobe    = s.dch_tick;
    assign act_request     = s.act_req;
    assign cust_data_en    = s.xparent;
    assign gci_slot_sel    = s.gci_slot; // RL8
    assign gci_slot_on     = s.slot_on;
    assign sf_tick         = s.sf_tick;
    assign interval_tick   = s.intv_tick;
    assign act_dchan_irq   = s.act_irq;
    assign irq             = s.irq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    far_count_up_a: assert property ( // RL1
        far_blk_err && !s.srst && !next_s.srst && !wr_hit && s.far_cnt != CNT_MAX
        |=> s.far_st && s.far_cnt == 8'($past(s.far_cnt) + 8'h01))
        else $error("far block error not counted");

    cnt_saturate_a: assert property ( // RL2
        near_blk_err && !s.roll && s.near_cnt == CNT_MAX && !wr_hit && !next_s.srst
        |=> s.near_cnt == CNT_MAX)
        else $error("near counter did not hold at FF");

    cnt_wrap_a: assert property ( // RL2
        far_blk_err && s.roll && s.far_cnt == CNT_MAX && !wr_hit && !next_s.srst
        |=> s.far_cnt == CNT_ZERO)
        else $error("far counter did not wrap to 00");

    interval_mark_a: assert property ( // RL3
        s.intv_tick |-> s.sf_tick && s.sf_cnt == '0
            && $past(s.sf_cnt) == SF_CNT_W'(SF_PER_INTERVAL - 1))
        else $error("interval tick not on the hundredth superframe");

    dch_code_a: assert property ( // RL5
        dch_evt && s.ie && !next_s.srst |=> s.nibble == CODE_DCH && s.dch_pend ##1 1'b1)
        else $error("D-channel byte did not load status F");

    dch_only_active_a: assert property ( // RL6
        $rose(s.dch_pend) |-> $past(access_on) && s.dch_tick)
        else $error("D-channel byte event outside active access");

    act_defer_a: assert property ( // RL7
        act_evt && s.dch_pend && !rd_dch && !next_s.srst
        |=> s.act_held && !$rose(s.act_pend) && s.held_code == $past(act_code))
        else $error("coinciding activation event not held");

    held_release_a: assert property ( // RL17
        rd_dch && s.act_held && !dch_evt && !act_evt && !next_s.srst
        |=> !s.dch_pend && s.act_pend && s.nibble == $past(s.held_code))
        else $error("held activation not shown after byte read");

    fail_code_a: assert property ( // RL16
        act_evt && act_code == CODE_FAIL && !s.dch_pend && !dch_evt && !next_s.srst
        |=> s.nibble == CODE_FAIL && s.act_pend)
        else $error("failed activation code not shown");

    irq_gate_a: assert property ( // RL13
        s.act_irq == (s.ie && (s.act_pend || s.dch_pend)))
        else $error("activation interrupt not gated by enable");

    slot_enable_a: assert property ( // RL9
        s.slot_on == s.slot_en[s.gci_slot])
        else $error("timeslot carries data without its enable");

    soft_reset_a: assert property ( // RL10
        s.srst |-> s.far_cnt == CNT_ZERO && s.near_cnt == CNT_ZERO && !s.dch_pend
            && s.nibble == 4'h0 && !s.act_irq)
        else $error("logic not held while soft reset set");

    overlay_hide_a: assert property ( // RL11
        s.bus == DCA_BUS_IDLE && avm_read && avm_address == OFF_SLOT_EN && !s.ovl_sel
        |=> !avm_waitrequest && avm_readdata == 32'h0000_0000)
        else $error("overlay register visible with overlay off");

    dch_byte_c: cover property (dch_evt && s.ie ##[1:8] rd_dch);
    held_act_c: cover property (act_evt && s.dch_pend ##[1:20] rd_dch && s.act_held);
    wrap_c:     cover property (far_blk_err && s.roll && s.far_cnt == CNT_MAX);
    interval_c: cover property (s.intv_tick);

endmodule

// >>> dca_pkg.sv
package dca_pkg;

    // clock and timing
    localparam int CLK_MHZ         = 125;
    localparam int SUPERFRAME_MS   = 12;
    localparam int INTERVAL_MS     = 1200;
    localparam int DCH_BYTE_US     = 500;
    localparam int SF_CYCLES       = SUPERFRAME_MS * 1000 * CLK_MHZ;
    localparam int DCH_CYCLES      = DCH_BYTE_US * CLK_MHZ;
    localparam int SF_PER_INTERVAL = INTERVAL_MS / SUPERFRAME_MS;
    localparam int SF_TMR_W        = 21;
    localparam int DCH_TMR_W       = 17;
    localparam int SF_CNT_W        = 7;

    // gci timeslots at a 4.096 MHz data_bit_clock
    localparam int GCI_SLOTS   = 8;
    localparam int GCI_SLOT_W  = 3;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL0    = 8'h00;
    localparam logic [7:0] OFF_ACT_STAT = 8'h04;
    localparam logic [7:0] OFF_ACT_CTRL = 8'h08;
    localparam logic [7:0] OFF_INT_SRC  = 8'h0C;
    localparam logic [7:0] OFF_INT_EN   = 8'h10;
    localparam logic [7:0] OFF_BLK_STAT = 8'h14;
    localparam logic [7:0] OFF_FAR_CNT  = 8'h18;
    localparam logic [7:0] OFF_NEAR_CNT = 8'h1C;
    localparam logic [7:0] OFF_OVL_SEL  = 8'h20;
    localparam logic [7:0] OFF_GCI_SLOT = 8'h24;
    localparam logic [7:0] OFF_SLOT_EN  = 8'h28;
    localparam logic [7:0] OFF_DCH_BYTE = 8'h2C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h30;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h34;
    localparam logic [7:0] OFF_SF_CNT   = 8'h38;

    // field positions
    localparam int CTRL0_SRST_BIT   = 3;
    localparam int ACTC_XPARENT_BIT = 0;
    localparam int ACTC_REQ_BIT     = 3;
    localparam int INTEN_ACT_BIT    = 3;
    localparam int INTSRC_ACT_BIT   = 3;
    localparam int BLK_FAR_BIT      = 0;
    localparam int BLK_NEAR_BIT     = 1;
    localparam int OVL_SEL_BIT      = 0;
    localparam int OVL_DCH_BIT      = 1;
    localparam int OVL_ROLL_BIT     = 2;
    localparam int IRQ_FAR_BIT      = 0;
    localparam int IRQ_NEAR_BIT     = 1;
    localparam int IRQ_DCH_BIT      = 2;
    localparam int IRQ_ACT_BIT      = 3;

    // activation status codes and counter limits
    localparam logic [3:0] CODE_DCH  = 4'hF;
    localparam logic [3:0] CODE_FAIL = 4'h4;
    localparam logic [3:0] CODE_UP_A = 4'hA;
    localparam logic [3:0] CODE_UP_B = 4'hB;
    localparam logic [7:0] CNT_MAX   = 8'hFF;
    localparam logic [7:0] CNT_ZERO  = 8'h00;

    typedef enum logic [0:0] {
        DCA_BUS_IDLE = 1'b0,
        DCA_BUS_ACK  = 1'b1
    } dca_bus_t;

endpackage

// >>> dca_mcu.sv
`timescale 1ns/1ps
// controller on the control port: one access at a time, held until the slave answers
module dca_mcu
    import dca_pkg::*;
(
    input  wire logic        clk_sys,
    output logic      [7:0]  avm_address,
    output logic             avm_read,
    output logic             avm_write,
    output logic      [3:0]  avm_byteenable,
    output logic      [31:0] avm_writedata,
    input  wire logic [31:0] avm_readdata,
    input  wire logic        avm_waitrequest
);
    initial begin
        avm_address    = 8'h00;
        avm_read       = 1'b0;
        avm_write      = 1'b0;
        avm_byteenable = 4'h0;
        avm_writedata  = 32'h0;
    end

    // the wait is bounded by the bench timeout, not here
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_sys);
        avm_address    <= a;
        avm_writedata  <= d;
        avm_byteenable <= be;
        avm_read       <= !wr;
        avm_write      <= wr;
        do @(posedge clk_sys); while (avm_waitrequest !== 1'b0);
        q = avm_readdata;
        avm_read  <= 1'b0;
        avm_write <= 1'b0;
    endtask

    // pulse the reset bit once, as done at power-up only
    task automatic soft_reset();
        logic [31:0] q;
        xfer(1'b1, OFF_CTRL0, 32'h8, 4'hF, q);
        xfer(1'b1, OFF_CTRL0, 32'h0, 4'hF, q);
    endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    import dca_pkg::*;
    localparam int DCH_N = 20;
    localparam int SF_N  = 30;
    logic        clk_sys, rst_b, avm_read, avm_write, avm_waitrequest;
    logic [7:0]  avm_address, dchan_rx_byte, dchan_tx_byte, rx;
    logic [3:0]  avm_byteenable, act_code;
    logic [31:0] avm_writedata, avm_readdata, q;
    logic        far_blk_err, near_blk_err, activated, act_evt, dchan_strobe;
    logic        act_request, cust_data_en, gci_slot_on, sf_tick, interval_tick;
    logic        act_dchan_irq, irq;
    logic [2:0]  gci_slot_sel;
    int          miscompares, tests_run, n, c, s, m;

    dca_top #(.DCH_CYCLES_P(DCH_N), .SF_CYCLES_P(SF_N)) dut (.clk_sys, .rst_b,
        .avm_address, .avm_read, .avm_write, .avm_byteenable, .avm_writedata,
        .avm_readdata, .avm_waitrequest, .far_blk_err, .near_blk_err, .activated,
        .act_evt, .act_code, .dchan_rx_byte, .dchan_tx_byte, .dchan_strobe,
        .act_request, .cust_data_en, .gci_slot_sel, .gci_slot_on, .sf_tick,
        .interval_tick, .act_dchan_irq, .irq);
    dca_mcu mcu (.clk_sys, .avm_address, .avm_read, .avm_write, .avm_byteenable,
        .avm_writedata, .avm_readdata, .avm_waitrequest);

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a);
        mcu.xfer(1'b0, a, 32'h0, 4'hF, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        mcu.xfer(1'b1, a, d, 4'hF, unused);
        #1;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK(q, e)
    endtask
    task automatic ev(input int which, input logic [3:0] code);
        @(posedge clk_sys);
        far_blk_err  <= (which == 0);
        near_blk_err <= (which == 1);
        act_evt      <= (which == 2);
        act_code     <= code;
        @(posedge clk_sys);
        far_blk_err  <= 1'b0;
        near_blk_err <= 1'b0;
        act_evt      <= 1'b0;
    endtask
    task automatic wait_pulse(input int which, output int cnt);
        logic hit;
        cnt = 0;
        hit = 1'b0;
        while (!hit) begin
            @(posedge clk_sys);
            #1;
            cnt++;
            hit = which == 0 ? sf_tick === 1'b1 :
                  which == 1 ? interval_tick === 1'b1 : dchan_strobe === 1'b1;
        end
    endtask
    // reference counter; saturation is the default, wrap only on request
    function automatic int bump(int v, bit roll);
        return roll ? (v + 1) % 256 : (v == 255 ? 255 : v + 1);
    endfunction
    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {rst_b, far_blk_err, near_blk_err, activated, act_evt} = 5'b0;
        act_code = 4'h0;
        dchan_rx_byte = 8'h00;
        miscompares = 0;
        tests_run = 0;
        void'($urandom(32'hf265f81f));
        repeat (2) @(posedge clk_sys);
        `CHK(avm_waitrequest, 1'b1)
        rst_b <= 1'b1;
        rc(OFF_FAR_CNT, 0);
        rc(8'h3C, 0);
        mcu.soft_reset();
        done("reset");

        wr(OFF_OVL_SEL, 32'h4);
        c = 250 + $urandom % 5;
        m = c;
        wr(OFF_FAR_CNT, c);
        repeat (6) begin
            ev(0, 4'h0);
            m = bump(m, 1'b1);
        end
        rc(OFF_FAR_CNT, m);
        `CHK((q - c) & 32'hFF, 32'd6)
        wr(OFF_OVL_SEL, 32'h0);
        m = c;
        wr(OFF_NEAR_CNT, c);
        repeat (6) begin
            ev(1, 4'h0);
            m = bump(m, 1'b0);
        end
        rc(OFF_NEAR_CNT, m);
        rc(OFF_BLK_STAT, 32'h3);
        mcu.xfer(1'b1, OFF_NEAR_CNT, 32'h11, 4'hE, q);
        rc(OFF_NEAR_CNT, m);
        rc(OFF_IRQ_STAT, 32'h3);
        `CHK(irq, 1'b0)
        wr(OFF_IRQ_MASK, 32'h1);
        `CHK(irq, 1'b1)
        wr(OFF_IRQ_STAT, 32'h1);
        `CHK(irq, 1'b0)
        rc(OFF_IRQ_STAT, 32'h2);
        done("errors");

        wr(OFF_GCI_SLOT, 32'h5);
        rc(OFF_GCI_SLOT, 0);
        wr(OFF_OVL_SEL, 32'h1);
        wr(OFF_SLOT_EN, 32'h8);
        for (s = 0; s < GCI_SLOTS; s++) begin
            wr(OFF_GCI_SLOT, s);
            `CHK(gci_slot_sel, s[2:0])
            `CHK(gci_slot_on, s == 3)
        end
        rc(OFF_GCI_SLOT, 32'h7);
        wr(OFF_OVL_SEL, 32'h0);
        rc(OFF_GCI_SLOT, 0);
        rc(OFF_SLOT_EN, 0);
        done("timeslot");

        wait_pulse(0, n);
        wait_pulse(0, n);
        `CHK(n, SF_N)
        wait_pulse(1, n);
        wait_pulse(1, n);
        `CHK(n, SF_N * SF_PER_INTERVAL)
        done("superframe");

        rx = 8'($urandom);
        @(posedge clk_sys);
        dchan_rx_byte <= rx;
        activated <= 1'b1;
        wr(OFF_INT_EN, 32'h8);
        wr(OFF_ACT_CTRL, 32'h9);
        `CHK({act_request, cust_data_en}, 2'b11)
        rc(OFF_ACT_CTRL, 32'h9);
        wr(OFF_OVL_SEL, 32'h2);
        wr(OFF_DCH_BYTE, {24'h0, ~rx});
        `CHK(dchan_tx_byte, ~rx)
        wait_pulse(2, n);
        wait_pulse(2, n);
        `CHK(n, DCH_N)
        `CHK(act_dchan_irq, 1'b1)
        // the event meets a pending byte, so it must stay hidden until the byte is read
        ev(2, CODE_FAIL);
        rc(OFF_INT_SRC, 32'h8);
        rc(OFF_ACT_STAT, CODE_DCH);
        rc(OFF_DCH_BYTE, rx);
        rc(OFF_ACT_STAT, CODE_FAIL);
        wr(OFF_OVL_SEL, 32'h0);
        rc(OFF_DCH_BYTE, 0);
        ev(2, CODE_UP_A);
        rc(OFF_ACT_STAT, CODE_UP_A);
        ev(2, CODE_UP_B);
        rc(OFF_ACT_STAT, CODE_UP_B);
        // no byte pending now, so a failed activation shows at once
        ev(2, CODE_FAIL);
        rc(OFF_ACT_STAT, CODE_FAIL);
        done("dchannel");

        wr(OFF_CTRL0, 32'h8);
        wr(OFF_FAR_CNT, 32'h5);
        ev(0, 4'h0);
        rc(OFF_FAR_CNT, 0);
        wr(OFF_CTRL0, 32'h0);
        `CHK({act_request, cust_data_en}, 2'b00)
        rc(OFF_FAR_CNT, 0);
        done("soft reset");
        tally_and_finish();
    end
endmodule
